// file: hdl/adc_host_ctrl.sv
// module: host controller that starts conversions and fetches results from the converter
`timescale 1ns/10ps
module adc_host_ctrl
#(
  parameter bit          FAST_VARIANT = 1'b1,
  parameter bit          BIPOLAR      = 1'b1,
  parameter int unsigned SCLK_HALF    = adc_host_pkg::SCLK_HALF_DEFAULT,
  parameter int unsigned BURST_BITS   = 8
)
(
  // clock and reset
  input  wire logic                                  clk_in,
  input  wire logic                                  rst_in,
  // user side
  input  wire logic                                  serial_mode_in,
  input  wire logic                                  sample_req_in,
  output logic                                       busy_out,
  output logic                                       result_valid_out,
  output logic signed [adc_host_pkg::RESULT_BITS:0]  result_out,
  output logic                                       timeout_out,
  // converter pins
  output logic                                       convert_start_n_out,
  output logic                                       mode_select_out,
  input  wire logic                                  conversion_done_n_in,
  output logic                                       chip_select_n_out,
  output logic                                       read_strobe_n_out,
  input  wire logic [adc_host_pkg::RESULT_BITS-1:0]  parallel_result_in,
  output logic                                       shift_clock_out,
  output logic                                       frame_enable_n_out,
  input  wire logic                                  serial_result_in
);
  import adc_host_pkg::*;

  localparam int unsigned CONV_CYC = FAST_VARIANT ? CONV_FAST_CYC : CONV_SLOW_CYC;
  localparam int unsigned ACQ_CYC  = FAST_VARIANT ? ACQ_FAST_CYC : ACQ_SLOW_CYC;

  // the data synchroniser needs four cycles before the falling edge samples
  if (SCLK_HALF < 4 || SCLK_HALF > 255 || BURST_BITS < 1 || BURST_BITS > FRAME_BITS)
  begin
    $error("adc_host_ctrl: unsupported parameter value");
  end

  typedef enum logic [2:0] {IDLE, START_LOW, WAIT_DONE, READ_PAR, READ_SER, ACQUIRE} state_t;
  state_t state;

  logic done_level;
  logic done_fall;
  logic data_sync_level;

  pin_sync done_sync
  (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .reset_level_in (1'b1),
    .pin_in         (conversion_done_n_in),
    .level_out      (done_level),
    .rise_out       (),
    .fall_out       (done_fall)
  );

  pin_sync data_sync
  (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .reset_level_in (1'b1),
    .pin_in         (serial_result_in),
    .level_out      (data_sync_level),
    .rise_out       (),
    .fall_out       ()
  );

  function automatic logic signed [RESULT_BITS:0] format_result(input logic [RESULT_BITS-1:0] raw);
    // bipolar parts code two's complement, unipolar straight binary
    if (BIPOLAR)
      format_result = {raw[RESULT_BITS-1], raw};
    else
      format_result = {1'b0, raw};
  endfunction

  logic [TIMER_BITS-1:0] timer;
  logic [TIMER_BITS-1:0] half_cnt;
  logic [4:0]            bit_cnt;
  logic [FRAME_BITS-1:0] shift_reg;
  logic                  gap;

  // serial bit capture point: synchroniser adds latency, so sample late in high half
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state               <= IDLE;
      timer               <= '0;
      half_cnt            <= '0;
      bit_cnt             <= '0;
      shift_reg           <= '0;
      gap                 <= 1'b0;
      busy_out            <= 1'b0;
      result_valid_out    <= 1'b0;
      result_out          <= '0;
      timeout_out         <= 1'b0;
      convert_start_n_out <= 1'b1;
      mode_select_out     <= 1'b1;
      chip_select_n_out   <= 1'b1;
      read_strobe_n_out   <= 1'b1;
      shift_clock_out     <= 1'b0;
      frame_enable_n_out  <= 1'b1;
    end
    else
    begin
      result_valid_out <= 1'b0;
      timeout_out      <= 1'b0;
      unique case (state)
        IDLE:
        begin
          // strap only changes between conversions
          mode_select_out <= ~serial_mode_in;
          if (sample_req_in && done_level)
          begin
            busy_out            <= 1'b1;
            convert_start_n_out <= 1'b0;
            timer               <= START_LOW_TICKS;
            state               <= START_LOW;
          end
        end
        START_LOW:
        begin
          if (timer == '0)
          begin
            // rising edge puts the converter into hold and converts
            convert_start_n_out <= 1'b1;
            timer               <= DONE_WAIT_TICKS;
            state               <= WAIT_DONE;
          end
          else
            timer <= timer - 1'b1;
        end
        WAIT_DONE:
        begin
          // no reads while converting select and read stay high
          if (done_fall)
          begin
            // falling done edge acts as our fetch trigger
            if (mode_select_out)
            begin
              chip_select_n_out <= 1'b0;
              read_strobe_n_out <= 1'b0;
              timer             <= TIMER_BITS'(DONE_PULSE_CYC);
              state             <= READ_PAR;
            end
            else
            begin
              frame_enable_n_out <= 1'b0;
              bit_cnt            <= '0;
              half_cnt           <= TIMER_BITS'(SCLK_HALF);
              gap                <= 1'b0;
              state              <= READ_SER;
            end
          end
          else if (timer == '0)
          begin
            timeout_out <= 1'b1;
            busy_out    <= 1'b0;
            state       <= IDLE;
          end
          else
            timer <= timer - 1'b1;
        end
        READ_PAR:
        begin
          // hold the strobes a done-pulse width so the bus settles
          if (timer == '0)
          begin
            result_out        <= format_result(parallel_result_in);
            result_valid_out  <= 1'b1;
            chip_select_n_out <= 1'b1;
            read_strobe_n_out <= 1'b1;
            timer             <= TIMER_BITS'(ACQ_CYC);
            state             <= ACQUIRE;
          end
          else
            timer <= timer - 1'b1;
        end
        READ_SER:
        begin
          if (half_cnt != '0)
            half_cnt <= half_cnt - 1'b1;
          else if (gap)
          begin
            // pause after every BURST_BITS bits, clock stopped low
            gap      <= 1'b0;
            half_cnt <= TIMER_BITS'(SCLK_HALF);
          end
          else if (!shift_clock_out)
          begin
            // rising edge makes the converter present the next bit
            shift_clock_out <= 1'b1;
            half_cnt        <= TIMER_BITS'(SCLK_HALF);
          end
          else
          begin
            // sample at the falling edge, a full half period after the change
            shift_clock_out <= 1'b0;
            shift_reg       <= {shift_reg[FRAME_BITS-2:0], data_sync_level};
            bit_cnt         <= bit_cnt + 5'd1;
            half_cnt        <= TIMER_BITS'(SCLK_HALF);
            gap <= ((5'(bit_cnt) + 5'd1) % 5'(BURST_BITS)) == 5'd0;
            if (bit_cnt == 5'(FRAME_BITS - 1))
            begin
              // frame enable rises to release the data line
              frame_enable_n_out <= 1'b1;
              // leading four bits are zeros, result follows MSB first
              result_out       <= format_result({shift_reg[RESULT_BITS-2:0], data_sync_level});
              result_valid_out <= 1'b1;
              timer            <= TIMER_BITS'(ACQ_CYC + READ_LEAD_CYC);
              state            <= ACQUIRE;
            end
          end
        end
        ACQUIRE:
        begin
          // acquisition must elapse before the next start
          if (timer == '0)
          begin
            busy_out <= 1'b0;
            state    <= IDLE;
          end
          else
            timer <= timer - 1'b1;
        end
      endcase
    end
  end
endmodule

// file: hdl/adc_host_pkg.sv
// package: constants for the converter host controller
package adc_host_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned CLK_MHZ         = CLK_HZ / 1000000;
  localparam int unsigned RESULT_BITS     = 12;
  localparam int unsigned FRAME_BITS      = 16;
  localparam int unsigned LEAD_ZEROS      = 4;
  // times in ns
  localparam int unsigned CONV_FAST_NS    = 1470;
  localparam int unsigned ACQ_FAST_NS     = 200;
  localparam int unsigned CONV_SLOW_NS    = 1600;
  localparam int unsigned ACQ_SLOW_NS     = 400;
  localparam int unsigned DONE_PULSE_NS   = 100;
  localparam int unsigned READ_LEAD_NS    = 200;
  localparam int unsigned START_LOW_NS    = 50;
  // least times round up
  localparam int unsigned CONV_FAST_CYC   = (CONV_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACQ_FAST_CYC    = (ACQ_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_SLOW_CYC   = (CONV_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACQ_SLOW_CYC    = (ACQ_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_LEAD_CYC   = (READ_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned START_LOW_CYC   = (START_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DONE_PULSE_CYC  = (DONE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TIMER_BITS      = 8;
  localparam logic [TIMER_BITS-1:0] SCLK_HALF_DEFAULT = 8'h04;
  localparam logic [TIMER_BITS-1:0] START_LOW_TICKS   = TIMER_BITS'(START_LOW_CYC);
  localparam logic [TIMER_BITS-1:0] DONE_WAIT_TICKS   = TIMER_BITS'(2 * CONV_SLOW_CYC);
endpackage

// file: hdl/pin_sync.sv
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic reset_level_in,
  // pin
  input  wire logic pin_in,
  // filtered level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1 <= reset_level_in;
      s2 <= reset_level_in;
      s3 <= reset_level_in;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      level_out <= reset_level_in;
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end
    else
    begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (s2 == s3 && s3 != level_out)
      begin
        level_out <= s3;
        rise_out  <= s3;
        fall_out  <= ~s3;
      end
    end
  end
endmodule

// file: tb/adc_device_model.sv
// model: behavioural converter seen from its pins
`timescale 1ns/10ps
module adc_device_model
#(
  parameter int CONV_NS = 1470, // slower parts take 1600
  parameter int ACQ_NS  = 200   // slower parts take 400
)
(
  input  wire logic        start_n_in,
  input  wire logic        mode_in,
  input  wire logic        cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        sclk_in,
  input  wire logic        frame_n_in,
  input  wire logic [11:0] code_in,
  input  wire logic        mute_in,
  output logic             done_n_out,
  output logic [11:0]      data_out,
  output logic             serial_result_out,
  output int               viol_out
);
  logic        converting = 1'b0;
  logic        armed      = 1'b0;
  event        go;
  time         done_at    = 0;
  logic [11:0] result     = 12'h000;
  int          idx        = 16;
  logic [15:0] word;
  initial done_n_out = 1'b1;
  initial viol_out = 0;
  assign word = {4'h0, result};
  // code_in already carries the variant's coding
  assign data_out = (mode_in && !cs_n_in && !rd_n_in) ? result : ~result;
  assign serial_result_out = (!mode_in && !frame_n_in && idx < 16)
                             ? word[15 - (idx < 0 ? 0 : idx)] : ~word[0];
  // only a rise after a real low level starts a conversion, not the step out of x at reset
  always @(negedge start_n_in) armed = 1'b1;
  // the start is judged apart from the conversion so a start during one is still seen
  always @(posedge start_n_in)
  begin
    if (armed)
    begin
      armed = 1'b0;
      if (converting || (done_at != 0 && $time - done_at < ACQ_NS))
        viol_out++;
      if (!converting)
        -> go;
    end
  end
  always @(go)
  begin
    converting = 1'b1;
    #(CONV_NS);
    result = code_in;
    converting = 1'b0;
    if (!mute_in)
    begin
      done_at = $time;
      done_n_out = 1'b0;
      #100 done_n_out = 1'b1;
    end
  end
  always @(negedge frame_n_in) idx = -1;
  // a paused shift clock simply holds the bit index
  always @(posedge sclk_in)
  begin
    if (!frame_n_in)
    begin
      if (converting)
        viol_out++;
      idx++;
    end
  end
endmodule

// file: tb/adc_host_ctrl_bench.sv
// bench: converter host controller against the converter model
`timescale 1ns/10ps
module adc_host_ctrl_bench;
  logic clk_in = 1'b0, rst_in = 1'b1, serial_mode_in = 1'b0, sample_req_in = 1'b0;
  logic busy_out, result_valid_out, timeout_out, start_n, mode_sel, done_n, cs_n, rd_n;
  logic sclk, frame_n, ser_bit, mute = 1'b0;
  logic signed [12:0] result_out;
  logic [11:0] par_data, code = 12'h000;
  int viol, failures = 0, n_checks = 0;
  always #12.5 clk_in = ~clk_in;
  adc_host_ctrl #(.FAST_VARIANT(1'b1), .BIPOLAR(1'b1)) dut_u (.clk_in(clk_in),
    .rst_in(rst_in), .serial_mode_in(serial_mode_in), .sample_req_in(sample_req_in),
    .busy_out(busy_out), .result_valid_out(result_valid_out), .result_out(result_out),
    .timeout_out(timeout_out), .convert_start_n_out(start_n), .mode_select_out(mode_sel),
    .conversion_done_n_in(done_n), .chip_select_n_out(cs_n), .read_strobe_n_out(rd_n),
    .parallel_result_in(par_data), .shift_clock_out(sclk), .frame_enable_n_out(frame_n),
    .serial_result_in(ser_bit));
  adc_device_model dev_u (.start_n_in(start_n), .mode_in(mode_sel), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .sclk_in(sclk), .frame_n_in(frame_n), .code_in(code), .mute_in(mute),
    .done_n_out(done_n), .data_out(par_data), .serial_result_out(ser_bit), .viol_out(viol));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_result(output logic [12:0] r, output logic tmo);
    int i;
    // step past the pulse that the previous call may have just seen
    @(negedge clk_in);
    for (i = 0; i < 600 && result_valid_out !== 1'b1 && timeout_out !== 1'b1; i++)
      @(negedge clk_in);
    r = result_out;
    tmo = timeout_out;
    if (i == 600)
    begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic request(input logic ser, input logic [11:0] c, output logic [12:0] r,
                         output logic tmo);
    int i;
    // a request while busy is ignored, so let the previous acquisition end first
    for (i = 0; i < 40 && busy_out !== 1'b0; i++)
      @(negedge clk_in);
    serial_mode_in = ser;
    code = c;
    sample_req_in = 1'b1;
    @(negedge clk_in);
    for (i = 0; i < 20 && busy_out !== 1'b1; i++)
      @(negedge clk_in);
    sample_req_in = 1'b0;
    check("request taken", 1, busy_out);
    wait_result(r, tmo);
  endtask
  task automatic s_reads();
    logic [11:0] codes [4] = '{12'h800, 12'h7FF, 12'hA5C, 12'h001};
    logic [12:0] r;
    logic t;
    foreach (codes[k])
    begin
      request(k[0], codes[k], r, t);
      check("result", {codes[k][11], codes[k]}, r);
    end
  endtask
  task automatic s_back_to_back();
    logic [12:0] r;
    logic t;
    code = 12'h123;
    sample_req_in = 1'b1;
    wait_result(r, t);
    check("first", 13'h0123, r);
    code = 12'hFED;
    @(negedge clk_in);
    wait_result(r, t);
    sample_req_in = 1'b0;
    check("second", 13'h1FED, r);
  endtask
  task automatic s_timeout();
    logic [12:0] r;
    logic t;
    mute = 1'b1;
    request(1'b0, 12'h055, r, t);
    check("timeout", 1, t);
    mute = 1'b0;
    repeat (20) @(negedge clk_in);
    request(1'b1, 12'h3C3, r, t);
    check("recovered", 13'h03C3, r);
  endtask
  initial
  begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    s_reads();
    s_back_to_back();
    s_timeout();
    check("host faults", 0, viol);
    end_of_test();
  end
endmodule

// file: tb/adc_host_ctrl_properties.sv
// checker: port timing checks for the converter host controller
`timescale 1ns/10ps
module adc_host_ctrl_checker
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic busy_out,
  input wire logic result_valid_out,
  input wire logic timeout_out,
  input wire logic convert_start_n_out,
  input wire logic mode_select_out,
  input wire logic conversion_done_n_in,
  input wire logic chip_select_n_out,
  input wire logic read_strobe_n_out,
  input wire logic shift_clock_out,
  input wire logic frame_enable_n_out
);
  logic [7:0] quiet;
  logic [7:0] since_done;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // counters saturate so a long idle gap never wraps into a short one
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      quiet <= 8'hFF;
    else if (!read_strobe_n_out || !frame_enable_n_out)
      quiet <= 8'h00;
    else if (quiet != 8'hFF)
      quiet <= quiet + 8'h01;
  end
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      since_done <= 8'hFF;
    else if ($fell(conversion_done_n_in))
      since_done <= 8'h00;
    else if (since_done != 8'hFF)
      since_done <= since_done + 8'h01;
  end
  chk_par_mode: assert property (!read_strobe_n_out |-> mode_select_out)
    else $error("read strobe low in serial mode");
  chk_ser_mode: assert property (!frame_enable_n_out |-> !mode_select_out)
    else $error("frame enable low in parallel mode");
  chk_cs_rd_pair: assert property (chip_select_n_out == read_strobe_n_out)
    else $error("select and read strobe differ");
  chk_strobe_released: assert property ($fell(read_strobe_n_out) |-> ##[1:8] read_strobe_n_out)
    else $error("read strobe held low");
  chk_frame_held: assert property ($rose(shift_clock_out) |-> !frame_enable_n_out)
    else $error("shift clock edge outside frame");
  chk_sclk_idle: assert property (frame_enable_n_out && $past(frame_enable_n_out) |-> !shift_clock_out)
    else $error("shift clock not idle low");
  chk_no_read_conv: assert property ($rose(convert_start_n_out) |-> (read_strobe_n_out && frame_enable_n_out) [*8])
    else $error("read during conversion");
  chk_read_lead: assert property ($rose(convert_start_n_out) |-> quiet >= 8'd8)
    else $error("read too close to start");
  chk_start_spacing: assert property ($rose(convert_start_n_out) |-> since_done >= 8'd8)
    else $error("start before acquisition over");
  chk_start_busy: assert property ($rose(busy_out) |-> !convert_start_n_out)
    else $error("start pulse not with busy");
  cov_par: cover property (result_valid_out && mode_select_out);
  cov_ser: cover property (result_valid_out && !mode_select_out);
  cov_tmo: cover property (timeout_out);
endmodule
bind adc_host_ctrl adc_host_ctrl_checker chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .busy_out(busy_out), .result_valid_out(result_valid_out), .timeout_out(timeout_out),
  .convert_start_n_out(convert_start_n_out), .mode_select_out(mode_select_out),
  .conversion_done_n_in(conversion_done_n_in), .chip_select_n_out(chip_select_n_out),
  .read_strobe_n_out(read_strobe_n_out), .shift_clock_out(shift_clock_out),
  .frame_enable_n_out(frame_enable_n_out));
